// >>> hw/mtio_trigger.v
/*
 * Trigger control for a capacitance meter: source selection, one-shot and
 * sweep starts, retrigger detection, trigger output pulse and an AXI4-Lite
 * register slave with a sticky, maskable interrupt.
 * Assumes the measurement engine reports reading, sweep, stop-time and
 * calculation state on the same clock, and bus events arrive as one-cycle
 * strobes from the bus interface logic on the same clock.
 */
`timescale 1ns/10ps
`include "mtio_defs.vh"

module mtio_trigger #(
   parameter PULSE_CYC = `MTIO_PULSE_CYC     // Output low time in cycles
) (
   aclk,
   aresetn,
   s_axi_awaddr,
   s_axi_awvalid,
   s_axi_awready,
   s_axi_wdata,
   s_axi_wstrb,
   s_axi_wvalid,
   s_axi_wready,
   s_axi_bresp,
   s_axi_bvalid,
   s_axi_bready,
   s_axi_araddr,
   s_axi_arvalid,
   s_axi_arready,
   s_axi_rdata,
   s_axi_rresp,
   s_axi_rvalid,
   s_axi_rready,
   rear_trig_in_n,
   panel_key,
   remote,
   bus_talk,
   bus_get,
   bus_commit,
   reading_done,
   sweep_done,
   calc_done,
   stop_time,
   start_reading,
   start_sweep,
   trig_out_n,
   irq
);
   input  wire        aclk;                 // System clock, 50 MHz
   input  wire        aresetn;              // Synchronous reset, active low
   input  wire [3:0]  s_axi_awaddr;         // Write address
   input  wire        s_axi_awvalid;        // Write address valid
   output wire        s_axi_awready;        // Write address ready
   input  wire [31:0] s_axi_wdata;          // Write data
   input  wire [3:0]  s_axi_wstrb;          // Write byte strobes
   input  wire        s_axi_wvalid;         // Write data valid
   output wire        s_axi_wready;         // Write data ready
   output reg  [1:0]  s_axi_bresp;          // Write response
   output reg         s_axi_bvalid;         // Write response valid
   input  wire        s_axi_bready;         // Write response ready
   input  wire [3:0]  s_axi_araddr;         // Read address
   input  wire        s_axi_arvalid;        // Read address valid
   output wire        s_axi_arready;        // Read address ready
   output reg  [31:0] s_axi_rdata;          // Read data
   output reg  [1:0]  s_axi_rresp;          // Read response
   output reg         s_axi_rvalid;         // Read data valid
   input  wire        s_axi_rready;         // Read data ready
   input  wire        rear_trig_in_n;       // Rear jack pin, leading edge falls
   input  wire        panel_key;            // Panel trigger key strobe
   input  wire        remote;               // Remote state locks the panel out
   input  wire        bus_talk;             // Bus talk addressing strobe
   input  wire        bus_get;              // Group execute trigger strobe
   input  wire        bus_commit;           // Device commit command strobe
   input  wire        reading_done;         // Engine finished one reading set
   input  wire        sweep_done;           // Engine finished the sweep steps
   input  wire        calc_done;            // Post-sweep calculations done
   input  wire        stop_time;            // Sweep is in its stop time
   output reg         start_reading;        // Start one reading set, pulse
   output reg         start_sweep;          // Start a full sweep, pulse
   output wire        trig_out_n;           // Trigger output jack, active low
   output wire        irq;                  // Level interrupt

   // Engine states
   localparam ST_IDLE = 2'd0;               // Waiting for a trigger
   localparam ST_READ = 2'd1;               // One-shot reading in progress
   localparam ST_SWP  = 2'd2;               // Sweep steps in progress
   localparam ST_CALC = 2'd3;               // Post-sweep calculations

   reg [31:0] ctrl_r;                       // Source, mode and rate
   reg [1:0]  state_r;                      // Engine state
   reg [1:0]  state_nxt;                    // Next engine state
   reg        queued_r;                     // Trigger caught in stop time
   reg [`MTIO_IRQ_W-1:0] istat_r;           // Sticky event bits
   reg [`MTIO_IRQ_W-1:0] imask_r;           // Interrupt enables
   reg        rear_s1_r;                    // Synchroniser first stage
   reg        rear_s2_r;                    // Synchroniser second stage
   reg        rear_s3_r;                    // Previous synchronised level
   reg        aw_full_r;                    // Write address held
   reg        w_full_r;                     // Write data held
   reg [3:0]  awaddr_r;                     // Held write address
   reg [31:0] wdata_r;                      // Held write data
   reg [3:0]  wstrb_r;                      // Held write strobes
   reg        pulse_go;                     // Start of output pulse
   reg        trig_acc;                     // Accepted trigger this cycle

   wire [2:0] src    = ctrl_r[`MTIO_CTRL_SRC_MSB:`MTIO_CTRL_SRC_LSB];
   wire       sweep  = ctrl_r[`MTIO_CTRL_SWEEP];
   wire [2:0] rate   = ctrl_r[`MTIO_CTRL_RATE_MSB:`MTIO_CTRL_RATE_LSB];
   wire       fast   = (rate == `MTIO_RATE_75) || (rate == `MTIO_RATE_1000);
   wire       rear_edge = rear_s3_r & ~rear_s2_r;
   wire       key_ok = panel_key & ~remote;
   wire       pulse_busy;                   // Output pulse still low
   wire       wr_go  = aw_full_r & w_full_r & ~s_axi_bvalid;
   wire       busy   = (state_r != ST_IDLE);
   reg        trig_any;                     // Stimulus from an active source
   reg        retrig;                       // Retrigger error event
   reg [31:0] rd_mux;                       // Read data selection
   reg        rd_hit;                       // Read address mapped

   // Rear jack passes two flops before the edge detector sees it.
   // The third flop only remembers the last settled level: the edge
   // costs one more cycle but never sees a metastable value.
   // All stages reset high, the idle jack level, so reset makes no edge.
   always @(posedge aclk) begin
      if (!aresetn) begin
         rear_s1_r <= 1'b1;
         rear_s2_r <= 1'b1;
         rear_s3_r <= 1'b1;
      end else begin
         rear_s1_r <= rear_trig_in_n;
         rear_s2_r <= rear_s1_r;
         rear_s3_r <= rear_s2_r;
      end
   end

   // Gate stimuli by source; the panel key is always live unless remote.
   // Bus strobes of an unselected kind are dropped here, so they can
   // neither start an operation nor raise a retrigger error.
   // Unused source codes fall back to the panel key alone.
   always @* begin
      trig_any = key_ok;
      case (src)
         `MTIO_SRC_PANEL:  trig_any = key_ok;
         `MTIO_SRC_REAR:   trig_any = key_ok | rear_edge;
         `MTIO_SRC_TALK:   trig_any = key_ok | bus_talk;
         `MTIO_SRC_GET:    trig_any = key_ok | bus_get;
         `MTIO_SRC_COMMIT: trig_any = key_ok | bus_commit;
         default:          trig_any = key_ok;
      endcase
   end

   // Engine sequencing, output pulse timing and retrigger detection.
   // A trigger while busy never changes state: the running operation
   // completes, and the sticky error bit records the overrun, except in sweep stop time, where the trigger is queued instead.
   // Rate codes above the five defined ones behave as slow rates.
   always @* begin
      state_nxt = state_r;
      pulse_go  = 1'b0;
      trig_acc  = 1'b0;
      retrig    = 1'b0;
      case (state_r)
         ST_IDLE: begin
            if (trig_any || queued_r) begin
               trig_acc  = 1'b1;
               state_nxt = sweep ? ST_SWP : ST_READ;
            end
         end
         ST_READ: begin
            retrig = trig_any;
            if (reading_done) begin
               pulse_go  = 1'b1;
               state_nxt = ST_IDLE;
            end
         end
         ST_SWP: begin
            // Stop-time triggers are queued, not flagged
            retrig = trig_any & ~stop_time;
            if (sweep_done) begin
               if (fast) begin
                  state_nxt = ST_CALC;
               end else begin
                  pulse_go  = 1'b1;
                  state_nxt = ST_IDLE;
               end
            end
         end
         ST_CALC: begin
            retrig = trig_any;
            if (calc_done) begin
               pulse_go  = 1'b1;
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   // State, start strobes and the stop-time queue.
   // The queue holds one trigger only; more stop-time triggers in the
   // same sweep merge into it rather than starting extra sweeps.
   always @(posedge aclk) begin
      if (!aresetn) begin
         state_r       <= ST_IDLE;
         queued_r      <= 1'b0;
         start_reading <= 1'b0;
         start_sweep   <= 1'b0;
      end else begin
         state_r       <= state_nxt;
         start_reading <= trig_acc & ~sweep;
         start_sweep   <= trig_acc & sweep;
         if (state_r == ST_SWP && stop_time && trig_any)
            queued_r <= 1'b1;
         else if (trig_acc)
            queued_r <= 1'b0;
      end
   end

   // Output pulse; a completion during a running pulse restarts the low
   // time, so two close completions merge into one longer pulse.
   // A 16-bit counter leaves ample room above the default low time.
   mtio_pulse #(
      .WIDTH  (16),
      .CYCLES (PULSE_CYC)
   ) u_pulse (
      .aclk    (aclk),
      .aresetn (aresetn),
      .start   (pulse_go),
      .pulse_n (trig_out_n),
      .busy    (pulse_busy)
   );

   // Write channels are taken independently and held until both arrive.
   // Each holding register takes one item, so a second write stalls
   // until the response of the first has been accepted by the master.
   assign s_axi_awready = ~aw_full_r;
   assign s_axi_wready  = ~w_full_r;
   assign s_axi_arready = ~s_axi_rvalid;
   assign irq           = |(istat_r & imask_r);

   // Write path and sticky status; a new event wins over a clear.
   // Only bytes 0 and 1 of the control word hold fields; the upper
   // bytes keep their reset value and read back as zero.
   // Writes to the read-only status word are answered OKAY and ignored.
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_r    <= 1'b0;
         w_full_r     <= 1'b0;
         awaddr_r     <= 4'h0;
         wdata_r      <= 32'h0000_0000;
         wstrb_r      <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `MTIO_RESP_OKAY;
         ctrl_r       <= `MTIO_CTRL_RST;
         imask_r      <= {`MTIO_IRQ_W{1'b0}};
         istat_r      <= {`MTIO_IRQ_W{1'b0}};
      end else begin
         if (s_axi_awvalid && !aw_full_r) begin
            aw_full_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_full_r) begin
            w_full_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (wr_go) begin
            aw_full_r    <= 1'b0;
            w_full_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `MTIO_RESP_OKAY;
            case (awaddr_r)
               `MTIO_OFF_CTRL: begin
                  if (wstrb_r[0])
                     ctrl_r[7:0] <= wdata_r[7:0];
                  if (wstrb_r[1])
                     ctrl_r[15:8] <= wdata_r[15:8];
               end
               `MTIO_OFF_IRQ_MASK: begin
                  if (wstrb_r[0])
                     imask_r <= wdata_r[`MTIO_IRQ_W-1:0];
               end
               `MTIO_OFF_STATUS, `MTIO_OFF_IRQ_STAT: begin
               end
               default: s_axi_bresp <= `MTIO_RESP_SLVERR;
            endcase
         end
         // Write-one-to-clear, then events set over it
         if (wr_go && awaddr_r == `MTIO_OFF_IRQ_STAT && wstrb_r[0])
            istat_r <= (istat_r & ~wdata_r[`MTIO_IRQ_W-1:0])
                       | {retrig, pulse_go};
         else
            istat_r <= istat_r | {retrig, pulse_go};
      end
   end

   // Read mux: status shows live engine state.
   // The jack level shown is the second synchroniser stage, never the
   // first, so software cannot capture a metastable value.
   always @* begin
      rd_hit = 1'b1;
      rd_mux = 32'h0000_0000;
      case (s_axi_araddr)
         `MTIO_OFF_CTRL:     rd_mux = {21'h0, ctrl_r[10:8], 3'h0, ctrl_r[4], 1'b0, ctrl_r[2:0]};
         `MTIO_OFF_STATUS:   rd_mux = {26'h0, rear_s2_r, pulse_busy, queued_r, busy, state_r};
         `MTIO_OFF_IRQ_STAT: rd_mux = {30'h0, istat_r};
         `MTIO_OFF_IRQ_MASK: rd_mux = {30'h0, imask_r};
         default:            rd_hit = 1'b0;
      endcase
   end

   // Read path: answer one cycle after the address is taken.
   // Data is captured when the address is taken and held until the
   // master accepts it, even if the status changes meanwhile.
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `MTIO_RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= rd_hit ? `MTIO_RESP_OKAY : `MTIO_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// >>> hw/mtio_defs.vh
/*
 * Constants for the measurement trigger control block: register offsets,
 * field positions, reset values, encodings and timing counts.
 * Assumes inclusion by bare name from plain Verilog-2005 design files.
 */
`ifndef MTIO_DEFS_VH
`define MTIO_DEFS_VH

// Register byte offsets on the AXI4-Lite slave
`define MTIO_OFF_CTRL      4'h0
`define MTIO_OFF_STATUS    4'h4
`define MTIO_OFF_IRQ_STAT  4'h8
`define MTIO_OFF_IRQ_MASK  4'hc

// Control register fields
`define MTIO_CTRL_SRC_LSB  0
`define MTIO_CTRL_SRC_MSB  2
`define MTIO_CTRL_SWEEP    4
`define MTIO_CTRL_RATE_LSB 8
`define MTIO_CTRL_RATE_MSB 10
`define MTIO_CTRL_RST      32'h0000_0000

// Trigger source encodings
`define MTIO_SRC_PANEL     3'h0
`define MTIO_SRC_REAR      3'h1
`define MTIO_SRC_TALK      3'h2
`define MTIO_SRC_GET       3'h3
`define MTIO_SRC_COMMIT    3'h4

// Reading rate encodings
`define MTIO_RATE_1        3'h0
`define MTIO_RATE_10       3'h1
`define MTIO_RATE_18       3'h2
`define MTIO_RATE_75       3'h3
`define MTIO_RATE_1000     3'h4

// Interrupt status bit positions
`define MTIO_IRQ_DONE      0
`define MTIO_IRQ_RETRIG    1
`define MTIO_IRQ_W         2

// Trigger output low time: figure in ns, cycles derived at 50 MHz
`define MTIO_CLK_NS        20
`define MTIO_PULSE_NS      1000
`define MTIO_PULSE_CYC     ((`MTIO_PULSE_NS + `MTIO_CLK_NS - 1) / `MTIO_CLK_NS)

// AXI responses
`define MTIO_RESP_OKAY     2'h0
`define MTIO_RESP_SLVERR   2'h2

`endif

// >>> hw/mtio_pulse.v
/*
 * Active-low pulse generator for the trigger output jack.
 * Assumes a one-cycle start strobe from logic on the same clock.
 */
`timescale 1ns/10ps
module mtio_pulse #(
   parameter WIDTH  = 8,                     // Counter width
   parameter CYCLES = 50                     // Low time in clock cycles
) (
   aclk,
   aresetn,
   start,
   pulse_n,
   busy
);
   input  wire             aclk;            // System clock
   input  wire             aresetn;         // Synchronous reset, active low
   input  wire             start;           // Start a new low pulse
   output reg              pulse_n;         // Trigger output, idles high
   output wire             busy;            // Pulse in progress

   reg [WIDTH-1:0] cnt_r;                   // Cycles left low

   assign busy = (cnt_r != {WIDTH{1'b0}});

   // Count down while low; a start during a pulse restarts it
   always @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r   <= {WIDTH{1'b0}};
         pulse_n <= 1'b1;
      end else if (start) begin
         cnt_r   <= CYCLES[WIDTH-1:0];
         pulse_n <= 1'b0;
      end else if (cnt_r != {WIDTH{1'b0}}) begin
         cnt_r   <= cnt_r - {{(WIDTH-1){1'b0}}, 1'b1};
         pulse_n <= (cnt_r == {{(WIDTH-1){1'b0}}, 1'b1});
      end
   end
endmodule

// >>> tb/mtio_trigger_asserts.sv
/* Port assertions for the trigger control block.
   Assumes the bind below and the pulse width of the instance. */
`timescale 1ns/10ps
module mtio_trigger_asserts #(
   parameter PULSE_CYC = 50                  // Output low time in cycles
) (
   input wire        aclk,
   input wire        aresetn,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        reading_done,
   input wire        sweep_done,
   input wire        calc_done,
   input wire        start_reading,
   input wire        start_sweep,
   input wire        trig_out_n,
   input wire        irq
);
   reg [15:0] low_cnt_r;                     // Low cycles seen so far

   // Count low samples; a repetition would need the count as a literal
   always @(posedge aclk) begin
      if (!aresetn || trig_out_n)
         low_cnt_r <= 16'h0000;
      else
         low_cnt_r <= low_cnt_r + 16'h0001;
   end

   default clocking dc @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_out_cause;
      $fell(trig_out_n) |-> $past(reading_done || sweep_done || calc_done);
   endproperty
   a_out_cause: assert property (p_out_cause) else $error("output fell with no completion");
   property p_out_width;
      $rose(trig_out_n) && $past(aresetn) |-> low_cnt_r == PULSE_CYC;
   endproperty
   a_out_width: assert property (p_out_width) else $error("output low time wrong");
   property p_out_max;
      !trig_out_n |-> low_cnt_r < PULSE_CYC;
   endproperty
   a_out_max: assert property (p_out_max) else $error("output held low too long");
   property p_start_excl;
      !(start_reading && start_sweep);
   endproperty
   a_start_excl: assert property (p_start_excl) else $error("both starts at once");
   property p_read_one;
      start_reading |=> !start_reading;
   endproperty
   a_read_one: assert property (p_read_one) else $error("reading start too long");
   property p_sweep_one;
      start_sweep |=> !start_sweep;
   endproperty
   a_sweep_one: assert property (p_sweep_one) else $error("sweep start too long");
   property p_reset_idle;
      disable iff (1'b0) !aresetn |=> trig_out_n && !start_reading && !start_sweep && !irq;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle in reset");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data not held");
endmodule

bind mtio_trigger mtio_trigger_asserts #(.PULSE_CYC(PULSE_CYC)) mtio_trigger_asserts_i (
   .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .reading_done, .sweep_done,
   .calc_done, .start_reading, .start_sweep, .trig_out_n, .irq);

// >>> tb/mtio_ext_model.sv
/* Far side: an outside instrument on the rear jack and a bus controller.
   Assumes tasks are called from the bench on the system clock. */
`timescale 1ns/10ps
module mtio_ext_model (
   input  wire  aclk,
   output logic rear_trig_in_n,
   output logic bus_talk,
   output logic bus_get,
   output logic bus_commit
);
   // Jack idles high through its pull-up; bus strobes idle low
   initial begin
      rear_trig_in_n = 1'b1;
      bus_talk = 1'b0;
      bus_get = 1'b0;
      bus_commit = 1'b0;
   end

   // Leading edge falls; held long so a trailing-edge start would show
   task automatic rear_pulse(input int len);
      @(posedge aclk);
      rear_trig_in_n <= 1'b0;
      repeat (len) @(posedge aclk);
      rear_trig_in_n <= 1'b1;
   endtask

   // One bus event of the chosen kind, one cycle long
   task automatic bus_event(input int k);
      @(posedge aclk);
      case (k)
         2: bus_talk <= 1'b1;
         3: bus_get <= 1'b1;
         default: bus_commit <= 1'b1;
      endcase
      @(posedge aclk);
      bus_talk <= 1'b0;
      bus_get <= 1'b0;
      bus_commit <= 1'b0;
   endtask
endmodule

// >>> tb/mtio_trigger_tb_top.sv
/* Self-checking bench for the trigger control block.
   Assumes the far-side model and the port checker bound to the design. */
`timescale 1ns/10ps
`include "mtio_defs.vh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
   $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module mtio_trigger_tb_top;
   localparam int P = 5;                     // Short pulse for simulation
   typedef struct packed {logic [2:0] src; logic [2:0] stim; logic rem; logic hit;} mtio_row_t;
   logic        aclk, aresetn, remote, stop_time;
   logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb, strb;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic        rear_trig_in_n, bus_talk, bus_get, bus_commit, start_reading, start_sweep, trig_out_n, irq;
   wire         panel_key = strb[0];         // Strobes from the bench
   wire         reading_done = strb[1];
   wire         sweep_done = strb[2];
   wire         calc_done = strb[3];
   int          errors, check_count, n_rd, n_sw, n_low, n0, f0;
   // Source, stimulus, remote, expected start count
   mtio_row_t   rows [14] = '{'{0,0,0,1}, '{0,1,0,0}, '{0,2,0,0}, '{1,1,0,1}, '{1,3,0,0}, '{1,2,0,0},
      '{1,0,0,1}, '{2,2,0,1}, '{2,0,0,1}, '{2,0,1,0}, '{3,3,0,1}, '{3,4,0,0}, '{4,4,0,1}, '{4,2,0,0}};

   mtio_trigger #(.PULSE_CYC(P)) mtio_trigger_i (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .rear_trig_in_n, .panel_key, .remote, .bus_talk, .bus_get, .bus_commit, .reading_done,
      .sweep_done, .calc_done, .stop_time, .start_reading, .start_sweep, .trig_out_n, .irq);
   mtio_ext_model mtio_ext_model_i (.aclk, .rear_trig_in_n, .bus_talk, .bus_get, .bus_commit);

   // 50 MHz clock
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   // Count starts and low cycles of the output, sampled before updates land
   always @(posedge aclk) begin
      if (start_reading === 1'b1) n_rd++;
      if (start_sweep === 1'b1) n_sw++;
      if (trig_out_n === 1'b0) n_low++;
   end

   function automatic logic [31:0] ctrl(input logic [2:0] s, input logic w, input logic [2:0] rt);
      return {21'h0, rt, 3'h0, w, 1'h0, s};
   endfunction

   // One write; address and data offered together, each released when taken
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      // No limit of its own: only the watchdog ends a hung write
      forever begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      s_axi_bready <= 1'b0;
      `CHK("bresp", `MTIO_RESP_OKAY, s_axi_bresp)
   endtask

   // One read, checking data only when the expected answer is OKAY
   task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      s_axi_rready <= 1'b0;
      `CHK("rresp", er, s_axi_rresp)
      if (er == `MTIO_RESP_OKAY) `CHK("rdata", e, s_axi_rdata)
   endtask

   task automatic strobe(input int b);
      @(posedge aclk);
      strb[b] <= 1'b1;
      @(posedge aclk);
      strb[b] <= 1'b0;
   endtask

   // Stimulus code: 0 panel key, 1 rear jack, 2..4 bus events
   task automatic stim(input int k);
      if (k == 0) strobe(0);
      else if (k == 1) mtio_ext_model_i.rear_pulse(12);
      else mtio_ext_model_i.bus_event(k);
   endtask

   task conclude;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Hang guard
   initial begin
      repeat (40000) @(posedge aclk);
      errors++;
      conclude();
   end

   initial begin
      {aresetn, remote, stop_time, strb, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`MTIO_OFF_CTRL, 32'h0, `MTIO_RESP_OKAY);
      rd(`MTIO_OFF_IRQ_STAT, 32'h0, `MTIO_RESP_OKAY);
      rd(`MTIO_OFF_IRQ_MASK, 32'h0, `MTIO_RESP_OKAY);
      rd(4'h2, 32'h0, `MTIO_RESP_SLVERR);
      $display("test reset done");
      foreach (rows[i]) begin
         wr(`MTIO_OFF_CTRL, ctrl(rows[i].src, 1'b0, 3'h0));
         @(posedge aclk);
         remote <= rows[i].rem;
         n0 = n_rd;
         stim(rows[i].stim);
         repeat (12) @(posedge aclk);
         `CHK("starts", int'(rows[i].hit), n_rd - n0)
         if (rows[i].hit) begin
            f0 = n_low;
            strobe(1);
            repeat (P + 4) @(posedge aclk);
            `CHK("one-shot low", P, n_low - f0)
         end
         remote <= 1'b0;
      end
      $display("test rows done");
      for (int rt = 0; rt < 5; rt++) begin
         wr(`MTIO_OFF_CTRL, ctrl(`MTIO_SRC_PANEL, 1'b1, 3'(rt)));
         n0 = n_sw;
         f0 = n_low;
         strobe(0);
         repeat (3) strobe(1);
         strobe(2);
         repeat (P + 4) @(posedge aclk);
         `CHK("sweep end low", (rt < 3) ? P : 0, n_low - f0)
         if (rt >= 3) begin
            strobe(3);
            repeat (P + 4) @(posedge aclk);
            `CHK("calc low", P, n_low - f0)
         end
         `CHK("sweeps", 1, n_sw - n0)
      end
      $display("test sweep rates done");
      wr(`MTIO_OFF_CTRL, ctrl(`MTIO_SRC_PANEL, 1'b0, 3'h0));
      wr(`MTIO_OFF_IRQ_STAT, 32'h3);
      n0 = n_rd;
      strobe(0);
      stim(3);
      rd(`MTIO_OFF_IRQ_STAT, 32'h0, `MTIO_RESP_OKAY);
      strobe(0);
      rd(`MTIO_OFF_IRQ_STAT, 32'h2, `MTIO_RESP_OKAY);
      `CHK("irq masked", 1'b0, irq)
      wr(`MTIO_OFF_IRQ_MASK, 32'h2);
      @(posedge aclk);
      `CHK("irq raised", 1'b1, irq)
      wr(`MTIO_OFF_IRQ_STAT, 32'h2);
      @(posedge aclk);
      `CHK("irq cleared", 1'b0, irq)
      f0 = n_low;
      strobe(1);
      repeat (P + 4) @(posedge aclk);
      `CHK("no abort low", P, n_low - f0)
      `CHK("no extra start", 1, n_rd - n0)
      $display("test retrigger done");
      wr(`MTIO_OFF_CTRL, ctrl(`MTIO_SRC_PANEL, 1'b1, 3'h0));
      wr(`MTIO_OFF_IRQ_STAT, 32'h3);
      n0 = n_sw;
      strobe(0);
      @(posedge aclk);
      stop_time <= 1'b1;
      strobe(0);
      rd(`MTIO_OFF_IRQ_STAT, 32'h0, `MTIO_RESP_OKAY);
      stop_time <= 1'b0;
      strobe(2);
      repeat (6) @(posedge aclk);
      `CHK("queued sweep", 2, n_sw - n0)
      strobe(2);
      repeat (P + 4) @(posedge aclk);
      $display("test stop time done");
      // Reset in mid-run, while an output pulse is low
      wr(`MTIO_OFF_CTRL, ctrl(`MTIO_SRC_PANEL, 1'b0, 3'h0));
      strobe(0);
      strobe(1);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      `CHK("reset out", 1'b1, trig_out_n)
      `CHK("reset irq", 1'b0, irq)
      aresetn <= 1'b1;
      rd(`MTIO_OFF_STATUS, 32'h20, `MTIO_RESP_OKAY);
      rd(`MTIO_OFF_CTRL, 32'h0, `MTIO_RESP_OKAY);
      rd(`MTIO_OFF_IRQ_MASK, 32'h0, `MTIO_RESP_OKAY);
      $display("test mid reset done");
      conclude();
   end
endmodule
